// >>> rtl/ppp_prom_port.v
`timescale 1ns/1ps
`default_nettype none
`include "ppp_map.vh"

// ----------------------------------------------------------------------
// Parallel programming port of the program memory
// ----------------------------------------------------------------------
// The device reset pin is a level input here: low selects programming
// mode. The block's own register reset is reset_n.
module ppp_prom_port (
  input  wire                   core_clk,
  input  wire                   reset_n,
  input  wire                   device_reset_in_n,
  input  wire [3:0]             analog_port_in,
  input  wire [7:0]             addr_mid_port_in,
  input  wire [3:0]             input_port_in,
  input  wire [3:0]             bidir_port_in,
  input  wire                   chip_enable_n,
  input  wire [7:0]             byte_port_in,
  output reg  [7:0]             byte_port_out,
  output reg  [7:0]             byte_port_oe,
  output reg                    prog_mode,
  output reg                    write_busy
);

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  reg rst_meta_reg;
  reg rst_sync_reg;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // --------------------------------------------------------------------
  // Pin decode
  // --------------------------------------------------------------------
  wire                   mode_active;
  wire                   output_gate_pin_n;
  wire                   supply_pin;
  wire [`PPP_ADDR_W-1:0] prog_addr;

  assign mode_active       = ~device_reset_in_n;
  assign output_gate_pin_n = input_port_in[2];
  assign supply_pin        = input_port_in[3];

  assign prog_addr[`PPP_A_LO_MSB:0] = analog_port_in[3:0];
  assign prog_addr[`PPP_A_MID_MSB:`PPP_A_MID_LSB] =
    addr_mid_port_in[7:1];
  assign prog_addr[`PPP_A_INT_MSB:`PPP_A_INT_LSB] =
    input_port_in[1:0];
  assign prog_addr[`PPP_A_TOP_MSB:`PPP_A_TOP_LSB] =
    bidir_port_in[1:0];

  // --------------------------------------------------------------------
  // Mode control
  // --------------------------------------------------------------------
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_READ  = 4'h2;
  localparam [3:0] ST_WRITE = 4'h4;
  localparam [3:0] ST_DONE  = 4'h8;

  reg  [3:0] state_reg;
  reg  [3:0] state_next;
  wire       rd_req;
  wire       wr_req;
  wire       mem_wr;
  wire [7:0] mem_rd;

  // Read-out needs both enables low; verify needs supply, enable high.
  assign rd_req = mode_active & ~output_gate_pin_n &
                  (~chip_enable_n | (supply_pin & chip_enable_n));
  assign wr_req = mode_active & supply_pin & output_gate_pin_n &
                  ~chip_enable_n;
  assign mem_wr = (state_reg == ST_IDLE) & wr_req;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (wr_req) begin
          state_next = ST_WRITE;
        end else if (rd_req) begin
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        if (!rd_req) begin
          state_next = ST_IDLE;
        end
      end
      ST_WRITE: begin
        state_next = ST_DONE;
      end
      ST_DONE: begin
        // One store per low chip-enable pulse.
        if (!wr_req) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg     <= ST_IDLE;
      byte_port_out <= 8'h00;
      byte_port_oe  <= 8'h00;
      prog_mode     <= 1'b0;
      write_busy    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      prog_mode  <= mode_active;
      write_busy <= (state_next == ST_WRITE);
      if (state_reg == ST_READ && rd_req) begin
        byte_port_out <= mem_rd;
        byte_port_oe  <= 8'hFF;
      end else begin
        byte_port_out <= 8'h00;
        byte_port_oe  <= 8'h00;
      end
    end
  end

  ppp_prom_array u_array (
    .clk     (core_clk),
    .rst_n   (rst_sync_reg),
    .wr_en   (mem_wr),
    .addr    (prog_addr),
    .wr_data (byte_port_in),
    .rd_data (mem_rd)
  );

endmodule

`default_nettype wire

// >>> rtl/ppp_map.vh
// Functional notes
// - Low reset selects the programming port mode
// - Address bits 0-3 from analog port
// - Address bits 11-12 from interrupt pins
// - Address bits 13-14 from bidirectional port
// - Read drives addressed byte onto byte port
// - Byte port floats when output gate high, or chip enable high without supply
// - Writes only with supply and output gate high
// - Chip enable low starts write of byte
// - Verify drives addressed byte with supply applied
`ifndef PPP_MAP_VH
`define PPP_MAP_VH

// ----------------------------------------------------------------------
// Memory geometry
// ----------------------------------------------------------------------
`define PPP_ADDR_W    15
`define PPP_DATA_W    8
`define PPP_MEM_DEPTH 32768
`define PPP_ERASED    8'hFF

// ----------------------------------------------------------------------
// Address field positions
// ----------------------------------------------------------------------
`define PPP_A_LO_MSB  3
`define PPP_A_MID_LSB 4
`define PPP_A_MID_MSB 10
`define PPP_A_INT_LSB 11
`define PPP_A_INT_MSB 12
`define PPP_A_TOP_LSB 13
`define PPP_A_TOP_MSB 14

`endif

// >>> rtl/ppp_prom_array.v
`timescale 1ns/1ps
`default_nettype none
`include "ppp_map.vh"

// ----------------------------------------------------------------------
// Program memory storage
// ----------------------------------------------------------------------
// One-time programmable cells: a program pulse can only clear bits,
// so a stored byte is the AND of its old value and the new byte.
module ppp_prom_array (
  input  wire                     clk,
  input  wire                     rst_n,
  input  wire                     wr_en,
  input  wire [`PPP_ADDR_W-1:0]   addr,
  input  wire [`PPP_DATA_W-1:0]   wr_data,
  output reg  [`PPP_DATA_W-1:0]   rd_data
);

  reg [`PPP_DATA_W-1:0] cell_reg [0:`PPP_MEM_DEPTH-1];

  always @(posedge clk) begin
    if (wr_en) begin
      cell_reg[addr] <= cell_reg[addr] & wr_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= cell_reg[addr];
    end
  end

  integer i;
  initial begin
    for (i = 0; i < `PPP_MEM_DEPTH; i = i + 1) begin
      cell_reg[i] = `PPP_ERASED;
    end
  end

endmodule

`default_nettype wire

// >>> sim/ppp_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_port_checker (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       device_reset_in_n,
  input wire logic [3:0] input_port_in,
  input wire logic       chip_enable_n,
  input wire logic [7:0] byte_port_out,
  input wire logic [7:0] byte_port_oe,
  input wire logic       prog_mode,
  input wire logic       write_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire gn = input_port_in[2];
  wire vp = input_port_in[3];
  mode_entry_a: assert property (!device_reset_in_n [*4] |=> prog_mode)
    else $error("no programming mode");
  mode_exit_a: assert property (device_reset_in_n [*2] |=> !prog_mode)
    else $error("programming mode stuck");
  float_port_a: assert property ((gn || (chip_enable_n && !vp))
    |=> byte_port_oe == 8'h00) else $error("port driven");
  quiet_out_a: assert property (byte_port_oe == 8'h00
    |-> byte_port_out == 8'h00) else $error("stale data");
  read_drive_a: assert property ((prog_mode && !gn
    && (!chip_enable_n || vp)) [*3] |=> byte_port_oe == 8'hFF)
    else $error("read not driven");
  write_gate_a: assert property (write_busy
    |-> $past(vp && gn && !chip_enable_n)) else $error("bad store");
  write_start_a: assert property ($fell(chip_enable_n) && vp && gn
    && prog_mode |=> write_busy) else $error("no store");
  write_once_a: assert property (write_busy |=> !write_busy)
    else $error("double store");
endmodule
bind ppp_prom_port ppp_port_checker u_chk (.core_clk, .reset_n,
  .device_reset_in_n, .input_port_in, .chip_enable_n, .byte_port_out,
  .byte_port_oe, .prog_mode, .write_busy);
`default_nettype wire

// >>> sim/ppp_programmer.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_programmer (
  input  wire logic        clk,
  input  wire logic [7:0]  bus,
  output var  logic [14:0] a = 15'h7FFF,
  output var  logic [7:0]  d = 8'hA5,
  output var  logic        ce_n = 1'b1,
  output var  logic        oe_n = 1'b1,
  output var  logic        vpp = 1'b0
);
  task automatic wr(input logic [14:0] ad, input logic [7:0] dt,
                    input logic v);
    @(posedge clk) #5;
    a = ad;
    d = dt;
    oe_n = 1'b1;
    vpp = v;
    @(posedge clk) #5 ce_n = 1'b0;
    repeat (2) @(posedge clk);
    #5 ce_n = 1'b1;
    @(posedge clk) #5 vpp = 1'b0;
    d = ~dt;
  endtask
  task automatic rd(input logic [14:0] ad, input logic v,
                    output logic [7:0] q);
    @(posedge clk) #5;
    a = ad;
    vpp = v;
    ce_n = v;
    oe_n = 1'b0;
    repeat (4) @(posedge clk);
    #5 q = bus;
    oe_n = 1'b1;
    ce_n = 1'b1;
    vpp = 1'b0;
    a = ~ad;
  endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        dev_n = 1'b0;
  logic [7:0]  q;
  wire  [14:0] a;
  wire  [7:0]  d, out, oe, bus;
  wire         ce_n, oe_n, vpp, mode, busy;
  int          n_stores = 0;
  int          failures = 0;
  int          n_checks = 0;
  logic [14:0] adr [6] = '{15'h6009, 15'h6410, 15'h6800, 15'h7000,
                           15'h4000, 15'h7FFF};
  assign bus = oe[0] ? out : d;
  always #25 core_clk = ~core_clk;
  // Counts store cycles so that refused writes can be seen to store nothing.
  always @(posedge core_clk) if (busy === 1'b1) n_stores++;
  ppp_programmer prog (.clk(core_clk), .bus, .a, .d, .ce_n, .oe_n, .vpp);
  ppp_prom_port uut (.core_clk, .reset_n, .device_reset_in_n(dev_n),
    .analog_port_in(a[3:0]), .addr_mid_port_in({a[10:4], 1'b0}),
    .input_port_in({vpp, oe_n, a[12:11]}),
    .bidir_port_in({2'b00, a[14:13]}), .chip_enable_n(ce_n),
    .byte_port_in(bus), .byte_port_out(out), .byte_port_oe(oe),
    .prog_mode(mode), .write_busy(busy));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_map;
    foreach (adr[i]) prog.wr(adr[i], 8'(8'h30 + i), 1'b1);
    foreach (adr[i]) begin
      prog.rd(adr[i], 1'b0, q);
      chk("read", q, 8'(8'h30 + i));
    end
    chk("stores", 8'(n_stores), 8'h06);
  endtask
  task automatic t_verify;
    prog.wr(15'h7FFF, 8'h0F, 1'b1);
    prog.rd(15'h7FFF, 1'b1, q);
    chk("verify", q, 8'h05);
  endtask
  task automatic t_inhibit;
    prog.wr(15'h6009, 8'h00, 1'b0);
    prog.rd(15'h6009, 1'b0, q);
    chk("inhibit", q, 8'h30);
    chk("inhibit stores", 8'(n_stores), 8'h07);
  endtask
  task automatic t_float_mode;
    repeat (2) @(posedge core_clk);
    #5 chk("float", oe, 8'h00);
    dev_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #5 chk("mode off", {7'h00, mode}, 8'h00);
    dev_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #5 chk("mode on", {7'h00, mode}, 8'h01);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    #5 reset_n = 1'b1;
    repeat (6) @(posedge core_clk);
    t_map;
    t_verify;
    t_inhibit;
    t_float_mode;
    give_verdict;
  end
  initial begin
    #200000;
    failures++;
    give_verdict;
  end
endmodule
`default_nettype wire
